// file: rtl/e1_tx_sa_bit_datalink_select.sv
/*
 * Transmit E1 spare-bit (Sa4..Sa8) data link selector with AXI4-Lite registers.
 * Each bit of the outbound stream comes from the serial input, the spare-bit
 * value register, the data link FIFO, or is forced to one.
 * Assumes bit_strobe and frame_sync come from framer timing on aclk;
 * ser_in is a pin and is synchronised here.
 */
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps

module e1_tx_sa_bit_datalink_select (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [e1_sa_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [e1_sa_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // data link bits from the hdlc side
    input wire logic dl_valid,
    input wire logic [e1_sa_pkg::LINK_FIFO_WIDTH-1:0] dl_data,
    output logic dl_ready,
    // transmit frame timing and serial stream
    input wire logic bit_strobe,
    input wire logic frame_sync,
    input wire logic ser_in,
    output logic tx_out,
    output logic tx_out_valid
);
    import e1_sa_pkg::*;
    // ************************************************************
    // register state
    // ************************************************************
    logic [7:0] tsdl_reg;
    logic [1:0] dl_src_reg;
    logic [7:0] src_sel_reg;
    logic [7:0] sa_value_reg;
    logic [7:0] underrun_reg;

    // ************************************************************
    // axi4-lite write path
    // ************************************************************
    logic aw_have_reg;
    logic w_have_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;

    wire aw_hs = awvalid & awready_reg;
    wire w_hs = wvalid & wready_reg;
    wire do_write = aw_have_reg & w_have_reg & ~bvalid_reg;
    wire aw_have_next = (aw_have_reg | aw_hs) & ~do_write;
    wire w_have_next = (w_have_reg | w_hs) & ~do_write;
    wire bvalid_next = do_write | (bvalid_reg & ~bready);

    wire wr_tsdl = (waddr_reg == TSDL_ADDR);
    wire wr_dl_src = (waddr_reg == DL_SRC_ADDR);
    wire wr_src_sel = (waddr_reg == SRC_SEL_ADDR);
    wire wr_sa_value = (waddr_reg == SA_VALUE_ADDR);
    wire wr_status = (waddr_reg == STATUS_ADDR);
    wire wr_mapped = wr_tsdl | wr_dl_src | wr_src_sel | wr_sa_value | wr_status;
    wire wr_lane0 = do_write & wstrb_reg[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            if (aw_hs) begin
                waddr_reg <= awaddr;
            end
            if (w_hs) begin
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            awready_reg <= ~aw_have_next & ~bvalid_next;
            wready_reg <= ~w_have_next & ~bvalid_next;
            bvalid_reg <= bvalid_next;
            if (do_write) begin
                bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // only byte lane 0 holds register bits; the status word is read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tsdl_reg <= TSDL_RST;
            dl_src_reg <= DL_SRC_RST;
            src_sel_reg <= SRC_SEL_RST;
            sa_value_reg <= SA_VALUE_RST;
        end else begin
            if (wr_lane0 && wr_tsdl) begin
                tsdl_reg <= wdata_reg[7:0];
            end
            if (wr_lane0 && wr_dl_src) begin
                dl_src_reg <= wdata_reg[1:0];
            end
            if (wr_lane0 && wr_src_sel) begin
                src_sel_reg <= wdata_reg[7:0];
            end
            if (wr_lane0 && wr_sa_value) begin
                sa_value_reg <= wdata_reg[7:0];
            end
        end
    end

    // ************************************************************
    // axi4-lite read path
    // ************************************************************
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic link_waiting;
    logic link_room;

    wire ar_hs = arvalid & arready_reg;
    wire rvalid_next = ar_hs | (rvalid_reg & ~rready);
    wire rd_tsdl = (araddr == TSDL_ADDR);
    wire rd_dl_src = (araddr == DL_SRC_ADDR);
    wire rd_src_sel = (araddr == SRC_SEL_ADDR);
    wire rd_sa_value = (araddr == SA_VALUE_ADDR);
    wire rd_status = (araddr == STATUS_ADDR);
    wire rd_mapped = rd_tsdl | rd_dl_src | rd_src_sel | rd_sa_value | rd_status;
    wire [31:0] status_word = {16'h0, underrun_reg, 6'h0, ~link_room, link_waiting};
    wire [31:0] rd_mux = rd_tsdl ? {24'h0, tsdl_reg} :
                         rd_dl_src ? {30'h0, dl_src_reg} :
                         rd_src_sel ? {24'h0, src_sel_reg} :
                         rd_sa_value ? {24'h0, sa_value_reg} :
                         rd_status ? status_word : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_hs) begin
                rdata_reg <= rd_mux;
                rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // ************************************************************
    // data link buffer
    // ************************************************************
    logic [LINK_FIFO_WIDTH-1:0] link_bit;
    logic link_pop;

    link_fifo #(
        .WIDTH(LINK_FIFO_WIDTH),
        .DEPTH(LINK_FIFO_DEPTH)
    ) u_link_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(dl_valid),
        .in_data(dl_data),
        .in_ready(link_room),
        .out_valid(link_waiting),
        .out_data(link_bit),
        .out_ready(link_pop)
    );
    assign dl_ready = link_room;

    // ************************************************************
    // frame position and spare-bit selection
    // ************************************************************
    logic ser_meta_reg;
    logic ser_sync_reg;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic nfas_reg;
    logic tx_out_reg;
    logic tx_out_valid_reg;

    // frame_sync marks bit 0 of a FAS frame; frames then alternate
    wire [BIT_CNT_W-1:0] pos = frame_sync ? '0 : bit_cnt_reg;
    wire nfas_now = frame_sync ? 1'b0 : nfas_reg;
    wire [2:0] bit_idx = pos[2:0];
    wire spare_slot = nfas_now & (pos[7:3] == 5'h0) & (bit_idx >= 3'(SA_LO_BIT));
    wire sa_enable = tsdl_reg[bit_idx];
    wire sa_from_reg = src_sel_reg[bit_idx];
    wire link_src_ok = (dl_src_reg == DL_CODE_HDLC);
    wire use_link = spare_slot & ~sa_from_reg & sa_enable & link_src_ok;
    // an empty buffer sends idle ones rather than stalling the line
    wire link_value = link_waiting ? link_bit[0] : 1'b1;
    wire spare_value = sa_from_reg ? sa_value_reg[bit_idx] :
                       ~sa_enable ? 1'b1 :
                       link_src_ok ? link_value : ser_sync_reg;
    wire next_bit = spare_slot ? spare_value : ser_sync_reg;
    wire underrun = bit_strobe & use_link & ~link_waiting;
    assign link_pop = bit_strobe & use_link;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser_meta_reg <= 1'b1;
            ser_sync_reg <= 1'b1;
            bit_cnt_reg <= '0;
            nfas_reg <= 1'b0;
            tx_out_reg <= 1'b1;
            tx_out_valid_reg <= 1'b0;
            underrun_reg <= 8'h00;
        end else begin
            ser_meta_reg <= ser_in;
            ser_sync_reg <= ser_meta_reg;
            tx_out_valid_reg <= bit_strobe;
            if (bit_strobe) begin
                bit_cnt_reg <= pos + 8'h01;
                nfas_reg <= (pos == FRAME_LAST_BIT) ? ~nfas_now : nfas_now;
                tx_out_reg <= next_bit;
            end
            if (underrun && underrun_reg != 8'hff) begin
                underrun_reg <= underrun_reg + 8'h01;
            end
        end
    end

    assign tx_out = tx_out_reg;
    assign tx_out_valid = tx_out_valid_reg;

    // ************************************************************
    // assertions
    // ************************************************************
    sequence s_spare_slot(int k);
        bit_strobe && !frame_sync && nfas_reg && bit_cnt_reg == 8'(k);
    endsequence

    sequence s_link_ready(int k);
        s_spare_slot(k) ##0 (tsdl_reg[k] && !src_sel_reg[k] && link_src_ok && link_waiting);
    endsequence

    property p_sa_link(int k);
        @(posedge aclk) disable iff (!aresetn)
        s_link_ready(k) |=> (tx_out_valid_reg && tx_out_reg == $past(link_bit[0]));
    endproperty
    a_sa_link8: assert property (p_sa_link(7)) else $error("Sa8 missed data link bit");
    a_sa_link7: assert property (p_sa_link(6)) else $error("Sa7 missed data link bit");
    a_sa_link6: assert property (p_sa_link(5)) else $error("Sa6 missed data link bit");
    a_sa_link5: assert property (p_sa_link(4)) else $error("Sa5 missed data link bit");
    a_sa_link4: assert property (p_sa_link(3)) else $error("Sa4 missed data link bit");

    property p_sa_forced_one;
        @(posedge aclk) disable iff (!aresetn)
        (bit_strobe && spare_slot && !sa_enable && !sa_from_reg) |=> tx_out_reg;
    endproperty
    a_sa_forced_one: assert property (p_sa_forced_one) else $error("disabled spare bit not one");

    property p_sa_pop_each_slot;
        @(posedge aclk) disable iff (!aresetn)
        (bit_strobe && use_link && link_waiting) |->
            link_pop ##1 (tx_out_valid_reg && tx_out_reg == $past(link_bit[0]));
    endproperty
    a_sa_pop_each_slot: assert property (p_sa_pop_each_slot) else $error("link bit not taken");

    property p_sa_pop_gated;
        @(posedge aclk) disable iff (!aresetn)
        link_pop |-> (dl_src_reg == DL_CODE_HDLC && !src_sel_reg[bit_idx] && spare_slot && bit_strobe);
    endproperty
    a_sa_pop_gated: assert property (p_sa_pop_gated) else $error("link bit used without hdlc source");

    property p_sa_from_reg;
        @(posedge aclk) disable iff (!aresetn)
        (bit_strobe && spare_slot && sa_from_reg) |=> tx_out_reg == $past(sa_value_reg[bit_idx]);
    endproperty
    a_sa_from_reg: assert property (p_sa_from_reg) else $error("register spare value not sent");

    property p_enables_reset;
        @(posedge aclk)
        !aresetn |=> (tsdl_reg[SA_HI_BIT:SA_LO_BIT] == 5'h0 && !link_pop);
    endproperty
    a_enables_reset: assert property (p_enables_reset) else $error("enables not clear after reset");

    property p_write_response;
        @(posedge aclk) disable iff (!aresetn)
        (aw_hs && w_hs && !bvalid_reg) |=> ##1 bvalid_reg;
    endproperty
    a_write_response: assert property (p_write_response) else $error("write response late");
endmodule : e1_tx_sa_bit_datalink_select

// file: rtl/link_fifo.sv
/*
 * Small synchronous FIFO holding data link bits before insertion.
 * Assumes one clock, synchronous active-low reset, DEPTH a power of two.
 */
`timescale 1ns/1ps
module link_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic ready_reg;

    wire push = in_valid & ready_reg;
    wire pop = out_valid & out_ready;

    assign in_ready = ready_reg;
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign count_next = count_reg + CNT_W'(push) - CNT_W'(pop);

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + PTR_W'(push);
            rd_ptr_reg <= rd_ptr_reg + PTR_W'(pop);
            count_reg <= count_next;
            ready_reg <= (count_next != FULL_CNT);
        end
    end

    property p_fifo_full_stalls;
        @(posedge aclk) disable iff (!aresetn)
        (count_reg == FULL_CNT) |-> !ready_reg;
    endproperty
    a_fifo_full_stalls: assert property (p_fifo_full_stalls)
        else $error("fifo accepts data while full");
endmodule : link_fifo

// file: shared/e1_sa_pkg.sv
/*
 * Shared constants for the transmit E1 spare-bit data link selector:
 * register indices and byte addresses, field positions, reset values, codes.
 * Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
 */
package e1_sa_pkg;
    // ************************************************************
    // register map (index, byte address = index * 4)
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] TSDL_IDX = 12'h10a;
    localparam logic [11:0] DL_SRC_IDX = 12'h109;
    localparam logic [11:0] SRC_SEL_IDX = 12'h130;
    localparam logic [11:0] SA_VALUE_IDX = 12'h131;
    localparam logic [11:0] STATUS_IDX = 12'h132;
    localparam logic [11:0] TSDL_ADDR = {TSDL_IDX[9:0], 2'b00};
    localparam logic [11:0] DL_SRC_ADDR = {DL_SRC_IDX[9:0], 2'b00};
    localparam logic [11:0] SRC_SEL_ADDR = {SRC_SEL_IDX[9:0], 2'b00};
    localparam logic [11:0] SA_VALUE_ADDR = {SA_VALUE_IDX[9:0], 2'b00};
    localparam logic [11:0] STATUS_ADDR = {STATUS_IDX[9:0], 2'b00};
    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int SA_LO_BIT = 3;
    localparam int SA_HI_BIT = 7;
    localparam logic [7:0] TSDL_RST = 8'h00;
    localparam logic [1:0] DL_SRC_RST = 2'h0;
    localparam logic [7:0] SRC_SEL_RST = 8'h00;
    localparam logic [7:0] SA_VALUE_RST = 8'hff;
    localparam logic [1:0] DL_CODE_HDLC = 2'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ************************************************************
    // frame timing and buffering
    // ************************************************************
    localparam int BIT_CNT_W = 8;
    localparam logic [7:0] FRAME_LAST_BIT = 8'hff;
    localparam int LINK_FIFO_DEPTH = 8;
    localparam int LINK_FIFO_WIDTH = 1;
endpackage : e1_sa_pkg

// file: tb/line_rx_model.sv
/*
 * Far-end line receiver model: watches the outbound bit stream and keeps
 * timeslot 0 of the non-FAS frame of each FAS/non-FAS pair.
 * Assumes tx_out_valid pulses exactly one cycle after each bit_strobe.
 */
`timescale 1ns/1ps
module line_rx_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // line timing seen by the far end
    input wire logic bit_strobe,
    input wire logic frame_sync,
    // outbound stream
    input wire logic tx_out,
    input wire logic tx_out_valid,
    // captured timeslot 0 of the non-FAS frame, bit k at position k
    output logic [7:0] ts0_nonfas
);
    logic sync_reg;
    logic [8:0] cnt_reg;
    logic [8:0] idx;

    // alignment comes from the strobe one cycle earlier, like a locked receiver
    assign idx = sync_reg ? 9'h000 : cnt_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_reg <= 1'b0;
            cnt_reg <= 9'h000;
            ts0_nonfas <= 8'h00;
        end else begin
            sync_reg <= bit_strobe & frame_sync;
            if (tx_out_valid) begin
                cnt_reg <= idx + 9'h001;
                if (idx[8] && idx[7:3] == 5'h00) begin
                    ts0_nonfas[idx[2:0]] <= tx_out;
                end
            end
        end
    end
endmodule : line_rx_model

// file: tb/tb.sv
/*
 * Self-checking bench for the transmit spare-bit data link selector.
 * Assumes the package constants and the hand-over timing of the design.
 */
`timescale 1ns/1ps
module tb;
    import e1_sa_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic dl_valid = 1'b0, dl_ready;
    logic [0:0] dl_data = 1'b0;
    logic bit_strobe = 1'b0, frame_sync = 1'b0, ser_in = 1'b0, tx_out, tx_out_valid;
    logic [7:0] ts0;
    int err_total = 0, num_checks = 0;

    always #5 aclk = ~aclk;

    e1_tx_sa_bit_datalink_select e1_tx_sa_bit_datalink_select_inst (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .dl_valid(dl_valid), .dl_data(dl_data), .dl_ready(dl_ready),
        .bit_strobe(bit_strobe), .frame_sync(frame_sync), .ser_in(ser_in),
        .tx_out(tx_out), .tx_out_valid(tx_out_valid));

    line_rx_model line_rx_model_inst (
        .aclk(aclk), .aresetn(aresetn), .bit_strobe(bit_strobe), .frame_sync(frame_sync),
        .tx_out(tx_out), .tx_out_valid(tx_out_valid), .ts0_nonfas(ts0));

    // ************************************************************
    // helpers
    // ************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task end_of_test;
        $display("errors %0d checks %0d", err_total, num_checks);
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test

    // bready is raised with the request and held until bvalid is seen
    task axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        chk({30'h0, r}, {30'h0, er}, "write response");
    endtask : axi_write

    task axi_read(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [1:0] r;
        logic [31:0] d;
        r = 2'h3;
        d = 32'hdead_beef;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                r = rresp;
                d = rdata;
                rready <= 1'b0;
                break;
            end
        end
        chk(d, exp, "read data");
        chk({30'h0, r}, {30'h0, er}, "read response");
    endtask : axi_read

    task cfg(input logic [7:0] en, input logic [1:0] src, input logic [7:0] sel, input logic [7:0] val);
        axi_write(TSDL_ADDR, {24'h0, en}, RESP_OKAY);
        axi_write(DL_SRC_ADDR, {30'h0, src}, RESP_OKAY);
        axi_write(SRC_SEL_ADDR, {24'h0, sel}, RESP_OKAY);
        axi_write(SA_VALUE_ADDR, {24'h0, val}, RESP_OKAY);
    endtask : cfg

    // bits go out lowest index first; each held until dl_ready is sampled high
    task push_bits(input logic [7:0] b, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            dl_valid <= 1'b1;
            dl_data <= b[i];
            for (int n = 0; n < 50; n++) begin
                @(posedge aclk);
                if (dl_ready === 1'b1) break;
                if (n == 49) begin
                    err_total++;
                    $display("MISMATCH t=%0t data link bit not taken", $time);
                end
            end
        end
        dl_valid <= 1'b0;
        @(posedge aclk);
    endtask : push_bits

    // one FAS frame then one non-FAS frame, a strobe every fourth cycle
    task frame_chk(input logic [7:0] exp, input string msg);
        for (int i = 0; i < 512; i++) begin
            @(posedge aclk);
            bit_strobe <= 1'b1;
            frame_sync <= (i == 0);
            @(posedge aclk);
            bit_strobe <= 1'b0;
            frame_sync <= 1'b0;
            repeat (2) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
        chk({24'h0, ts0}, {24'h0, exp}, msg);
    endtask : frame_chk

    // ************************************************************
    // scenarios
    // ************************************************************
    task t_reset_state;
        axi_read(TSDL_ADDR, {24'h0, TSDL_RST}, RESP_OKAY);
        axi_read(DL_SRC_ADDR, {30'h0, DL_SRC_RST}, RESP_OKAY);
        axi_read(SRC_SEL_ADDR, {24'h0, SRC_SEL_RST}, RESP_OKAY);
        axi_read(SA_VALUE_ADDR, {24'h0, SA_VALUE_RST}, RESP_OKAY);
        axi_read(STATUS_ADDR, 32'h0, RESP_OKAY);
        axi_write(12'h42c, 32'h0000_00ff, RESP_SLVERR);
        axi_read(12'h42c, 32'h0, RESP_SLVERR);
    endtask : t_reset_state

    task t_default_frame;
        frame_chk(8'hf8, "spare bits forced to one");
    endtask : t_default_frame

    // only the enabled slot takes the queued zero, the rest stay one
    task t_each_enable;
        for (int k = SA_LO_BIT; k <= SA_HI_BIT; k++) begin
            cfg(8'h01 << k, DL_CODE_HDLC, 8'h00, 8'hff);
            push_bits(8'h00, 1);
            frame_chk(8'hf8 & ~(8'h01 << k), "single enable slot");
        end
        axi_read(STATUS_ADDR, 32'h0, RESP_OKAY);
    endtask : t_each_enable

    // fill the queue to refusal, then drain it across two frames into underrun
    task t_fifo_order;
        logic [7:0] b;
        b = 8'b0110_1101;
        cfg(8'hf8, DL_CODE_HDLC, 8'h00, 8'hff);
        axi_read(TSDL_ADDR, 32'h0000_00f8, RESP_OKAY);
        push_bits(b, 8);
        repeat (2) @(posedge aclk);
        chk({31'h0, dl_ready}, 32'h0, "queue full refuses");
        axi_read(STATUS_ADDR, 32'h0000_0003, RESP_OKAY);
        frame_chk({b[4:0], 3'b000}, "first frame link bits");
        frame_chk({2'b11, b[7:5], 3'b000}, "second frame with underrun");
        axi_read(STATUS_ADDR, 32'h0000_0200, RESP_OKAY);
    endtask : t_fifo_order

    task t_select_and_source;
        cfg(8'hf8, DL_CODE_HDLC, 8'ha8, 8'h00);
        frame_chk(8'h50, "register-sourced bits skip link");
        axi_read(STATUS_ADDR, 32'h0000_0400, RESP_OKAY);
        cfg(8'hf8, 2'h0, 8'h00, 8'h00);
        ser_in <= 1'b1;
        frame_chk(8'hff, "non-hdlc source passes serial");
        ser_in <= 1'b0;
        cfg(8'h00, 2'h0, 8'hf8, 8'h28);
        frame_chk(8'h28, "value register drives spare bits");
    endtask : t_select_and_source

    // a reset in mid-run must clear enables written before it
    task t_mid_reset;
        cfg(8'hf8, DL_CODE_HDLC, 8'h00, 8'hff);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(TSDL_ADDR, {24'h0, TSDL_RST}, RESP_OKAY);
        frame_chk(8'hf8, "enables clear after mid-run reset");
    endtask : t_mid_reset

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_state();
        t_default_frame();
        t_each_enable();
        t_fifo_order();
        t_select_and_source();
        t_mid_reset();
        end_of_test();
    end

    // about three times the expected run of some 25000 cycles
    initial begin
        #800000;
        err_total++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_of_test();
    end
endmodule : tb
